// file: logic/tfs_sensor.sv
// temperature frequency sensor: two-phase oscillator measurement
`default_nettype none
`timescale 1ns/10ps

module tfs_sensor
	import tfs_pkg::*;
#(
	parameter int GAIN_W = TFS_GAIN_W,
	parameter int RES_W = TFS_RES_W,
	parameter int TRIM_W = TFS_TRIM_W
)
(
	input wire logic clk,
	input wire logic rst_n,
	// second control register: start command, never protected
	input wire logic start,
	// interrupt flag register: ready clear, never protected
	input wire logic ready_clear,
	// calibration register writes
	input wire logic gain_wr,
	input wire logic [GAIN_W-1:0] gain_wdata,
	input wire logic offset_wr,
	input wire logic [RES_W-1:0] offset_wdata,
	input wire logic cal_wr,
	input wire logic [TRIM_W-1:0] frequency_trim_wdata,
	input wire logic [TRIM_W-1:0] temperature_trim_wdata,
	// access protection
	input wire logic write_protect,
	input wire logic debug_access,
	// thermal oscillator
	input wire logic thermal_osc_in,
	output logic thermal_osc_enable,
	output logic thermal_osc_max_cfg,
	output logic [TRIM_W-1:0] frequency_trim,
	output logic [TRIM_W-1:0] temperature_trim,
	// status and readback
	output logic [GAIN_W-1:0] gain_value,
	output logic [RES_W-1:0] offset_value,
	output logic [RES_W-1:0] result,
	output logic result_ready,
	output logic busy,
	output logic write_refused
);

	// =====================================================================
	// parameter check
	if (GAIN_W < 1 || RES_W < 2 || TRIM_W < 1)
	begin : g_chk
		$error("unsupported width parameters");
	end

	// =====================================================================
	// calibration registers
	logic [GAIN_W-1:0] gain_q;
	logic [GAIN_W-1:0] gain_d;
	logic [RES_W-1:0] offset_q;
	logic [RES_W-1:0] offset_d;
	logic [TRIM_W-1:0] ftrim_q;
	logic [TRIM_W-1:0] ftrim_d;
	logic [TRIM_W-1:0] ttrim_q;
	logic [TRIM_W-1:0] ttrim_d;
	logic refused_q;
	logic refused_d;
	logic wr_allowed;
	logic any_cal_wr;

	always_comb
	begin
		// debugger accesses ignore protection
		wr_allowed = !write_protect || debug_access; // [R5] [R6]
		any_cal_wr = gain_wr || offset_wr || cal_wr;
		gain_d = gain_q;
		offset_d = offset_q;
		ftrim_d = ftrim_q;
		ttrim_d = ttrim_q;
		refused_d = any_cal_wr && !wr_allowed; // [R5]
		if (wr_allowed)
		begin
			if (gain_wr)
			begin
				gain_d = gain_wdata;
			end
			if (offset_wr)
			begin
				offset_d = offset_wdata;
			end
			if (cal_wr)
			begin
				ftrim_d = frequency_trim_wdata;
				ttrim_d = temperature_trim_wdata;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gain_q <= GAIN_W'(TFS_GAIN_RST);
			offset_q <= RES_W'(TFS_OFFSET_RST);
			ftrim_q <= TRIM_W'(TFS_TRIM_RST);
			ttrim_q <= TRIM_W'(TFS_TRIM_RST);
			refused_q <= 1'b0;
		end
		else
		begin
			gain_q <= gain_d;
			offset_q <= offset_d;
			ftrim_q <= ftrim_d;
			ttrim_q <= ttrim_d;
			refused_q <= refused_d;
		end
	end

	// =====================================================================
	// measurement sequencer
	tfs_state_e state_q;
	tfs_state_e state_d;
	logic [GAIN_W-1:0] timer_q;
	logic [GAIN_W-1:0] timer_d;
	logic [RES_W-1:0] result_q;
	logic [RES_W-1:0] result_d;
	logic ready_q;
	logic ready_d;
	logic cnt_clear;
	logic signed [RES_W-1:0] cnt_value;
	logic last_cycle;

	always_comb
	begin
		state_d = state_q;
		timer_d = timer_q;
		result_d = result_q;
		cnt_clear = 1'b0;
		// a zero gain still gives each phase one cycle
		last_cycle = (timer_q <= GAIN_W'(1));
		// set wins over clear
		ready_d = ready_q;
		if (ready_clear)
		begin
			ready_d = 1'b0;
		end
		unique case (state_q)
			TFS_IDLE:
			begin
				if (start)
				begin
					cnt_clear = 1'b1;
					timer_d = gain_q; // [R2]
					state_d = TFS_PH_MIN; // [R10]
				end
			end
			TFS_PH_MIN:
			begin
				if (last_cycle)
				begin
					timer_d = gain_q; // [R2]
					state_d = TFS_PH_MAX; // [R1]
				end
				else
				begin
					timer_d = timer_q - GAIN_W'(1);
				end
			end
			TFS_PH_MAX:
			begin
				if (last_cycle)
				begin
					state_d = TFS_CORRECT;
				end
				else
				begin
					timer_d = timer_q - GAIN_W'(1);
				end
			end
			TFS_CORRECT:
			begin
				result_d = RES_W'($signed(offset_q) + cnt_value); // [R4]
				ready_d = 1'b1; // [R10]
				state_d = TFS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= TFS_IDLE;
			timer_q <= '0;
			result_q <= RES_W'(TFS_RESULT_RST);
			ready_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			timer_q <= timer_d;
			result_q <= result_d;
			ready_q <= ready_d;
		end
	end

	// =====================================================================
	// oscillator edge counter
	tfs_edge_counter #(
		.CNT_W(RES_W)
	) u_counter (
		.clk(clk),
		.rst_n(rst_n),
		.clear(cnt_clear),
		.enable(state_q == TFS_PH_MIN || state_q == TFS_PH_MAX), // [R3]
		.count_down(state_q == TFS_PH_MAX), // [R3]
		.osc_in(thermal_osc_in),
		.count(cnt_value)
	);

	// =====================================================================
	// outputs
	assign thermal_osc_enable = (state_q == TFS_PH_MIN) || (state_q == TFS_PH_MAX);
	assign thermal_osc_max_cfg = (state_q == TFS_PH_MAX); // [R1]
	assign frequency_trim = ftrim_q;
	assign temperature_trim = ttrim_q;
	assign gain_value = gain_q;
	assign offset_value = offset_q;
	assign result = result_q;
	assign result_ready = ready_q;
	assign busy = (state_q != TFS_IDLE);
	assign write_refused = refused_q;

endmodule // tfs_sensor

`default_nettype wire

// file: logic/tfs_pkg.sv
// constants and types shared by the temperature frequency sensor
//
// Summary of operation
// (R1) measure oscillator twice: min then max
// (R2) phase length is gain reference-clock periods
// (R3) counter counts up phase one, down two
// (R4) signed count plus offset gives result
// (R5) protection spares control and flag clearing
// (R6) debugger writes bypass write protection
// (R7) software loads factory gain, offset, trims
// (R8) software rescales gain for other references
// (R9) software enables reference clock before measuring
// (R10) start command begins; ready flag on result
`default_nettype none

package tfs_pkg;

	// =====================================================================
	// widths
	localparam int TFS_RES_W = 24;
	localparam int TFS_GAIN_W = 24;
	localparam int TFS_TRIM_W = 6;

	// =====================================================================
	// clock
	localparam int TFS_CLK_PERIOD_NS = 25;

	// =====================================================================
	// values after reset
	localparam logic [TFS_GAIN_W-1:0] TFS_GAIN_RST = 24'h000000;
	localparam logic [TFS_RES_W-1:0] TFS_OFFSET_RST = 24'h000000;
	localparam logic [TFS_RES_W-1:0] TFS_RESULT_RST = 24'h000000;
	localparam logic [TFS_TRIM_W-1:0] TFS_TRIM_RST = 6'h00;

	// =====================================================================
	// measurement sequence
	typedef enum logic [1:0] {
		TFS_IDLE = 2'b00,
		TFS_PH_MIN = 2'b01,
		TFS_PH_MAX = 2'b10,
		TFS_CORRECT = 2'b11
	} tfs_state_e;

endpackage : tfs_pkg

`default_nettype wire

// file: logic/tfs_edge_counter.sv
// up/down counter of thermal oscillator rising edges
`default_nettype none
`timescale 1ns/10ps

module tfs_edge_counter
	import tfs_pkg::*;
#(
	parameter int CNT_W = TFS_RES_W
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic enable,
	input wire logic count_down,
	input wire logic osc_in,
	output logic signed [CNT_W-1:0] count
);

	// =====================================================================
	// parameter check
	if (CNT_W < 2)
	begin : g_chk
		$error("counter width must be at least two");
	end

	logic osc_q;
	logic osc_d;
	logic signed [CNT_W-1:0] cnt_q;
	logic signed [CNT_W-1:0] cnt_d;
	logic rise;

	// =====================================================================
	// edge detection and counting
	always_comb
	begin
		osc_d = osc_in;
		rise = osc_in & ~osc_q;
		cnt_d = cnt_q;
		if (clear)
		begin
			cnt_d = '0;
		end
		else if (enable && rise)
		begin
			if (count_down)
			begin
				cnt_d = cnt_q - CNT_W'(1); // [R3]
			end
			else
			begin
				cnt_d = cnt_q + CNT_W'(1); // [R3]
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			osc_q <= 1'b0;
			cnt_q <= '0;
		end
		else
		begin
			osc_q <= osc_d;
			cnt_q <= cnt_d;
		end
	end

	assign count = cnt_q;

endmodule // tfs_edge_counter

`default_nettype wire

// file: verif/tfs_sensor_checker.sv
// port assertions for the temperature frequency sensor
`timescale 1ns/10ps
`default_nettype none
module tfs_sensor_checker
	import tfs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic ready_clear,
	input wire logic gain_wr,
	input wire logic write_protect,
	input wire logic debug_access,
	input wire logic thermal_osc_enable,
	input wire logic thermal_osc_max_cfg,
	input wire logic [TFS_GAIN_W-1:0] gain_value,
	input wire logic result_ready,
	input wire logic busy,
	input wire logic write_refused
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
logic [23:0] n_q, n_d;
always_comb n_d = thermal_osc_enable ? n_q + 24'h1 : 24'h0;
always_ff @(posedge clk or negedge rst_n)
	if (!rst_n) n_q <= 24'h0;
	else n_q <= n_d;
sequence s_fin;
	!thermal_osc_enable && busy ##1 result_ready && !busy;
endsequence
property p_ref; gain_wr && write_protect && !debug_access |=> write_refused; endproperty
a_ref: assert property (p_ref) else $error("no refusal");
property p_dbg; debug_access |=> !write_refused; endproperty
a_dbg: assert property (p_dbg) else $error("debug refused");
property p_go; start && !busy |=> busy && thermal_osc_enable && !thermal_osc_max_cfg; endproperty
a_go: assert property (p_go) else $error("bad start");
property p_ord; $rose(thermal_osc_max_cfg) |-> $past(thermal_osc_enable) && busy; endproperty
a_ord: assert property (p_ord) else $error("bad order");
property p_len; $fell(thermal_osc_enable) |->
	n_q == ((gain_value == 24'h0) ? 24'h2 : gain_value << 1); endproperty
a_len: assert property (p_len) else $error("bad length");
property p_fin; $fell(thermal_osc_enable) |-> s_fin; endproperty
a_fin: assert property (p_fin) else $error("bad finish");
property p_clr; ready_clear && !busy |=> !result_ready; endproperty
a_clr: assert property (p_clr) else $error("no clear");
property p_rdy; $rose(result_ready) |-> $past(busy) && !busy; endproperty
a_rdy: assert property (p_rdy) else $error("bad ready");
endmodule // tfs_sensor_checker
bind tfs_sensor tfs_sensor_checker chk (.*);
`default_nettype wire

// file: verif/tfs_sensor_tb.sv
// self-checking bench for the temperature frequency sensor
`timescale 1ns/10ps
`default_nettype none
module tfs_sensor_tb import tfs_pkg::*;;
logic clk = 0, rst_n = 0, start = 0, ready_clear = 0, gain_wr = 0, offset_wr = 0, cal_wr = 0;
logic write_protect = 0, debug_access = 0, thermal_osc_in = 0;
logic [23:0] gain_wdata = '0, offset_wdata = '0, gain_value, offset_value, result;
logic [5:0] frequency_trim_wdata = '0, temperature_trim_wdata = '0;
logic [5:0] frequency_trim, temperature_trim;
logic thermal_osc_enable, thermal_osc_max_cfg, result_ready, busy, write_refused;
int miscompares = 0, checks_done = 0;
// gain, offset, up-phase spacing, down-phase spacing, expected result
int rows[4][5] = '{'{8, 0, 2, 3, 2}, '{0, 5, 0, 0, 5}, '{16, -100, 2, 0, -92}, '{5, 1, 0, 2, -2}};
tfs_sensor dut (.*);
initial forever #(TFS_CLK_PERIOD_NS / 2.0) clk = ~clk;
task automatic ck(string n, logic [23:0] e, logic [23:0] s);
	checks_done++;
	if (s !== e)
	begin
		$display("mismatch %s exp %h got %h", n, e, s);
		miscompares++;
	end
endtask
task automatic step(int n);
	repeat (n) @(posedge clk);
	#1;
endtask
task conclude;
	$display("checks_done %0d miscompares %0d", checks_done, miscompares);
	if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
	else $display("*** FAIL ***");
	$finish;
endtask
// second start is held into the busy cycle and must be ignored
task automatic conv(int g, int o, int dn, int dx, int r);
	int gx, e, d;
	logic p, v;
	gx = (g == 0) ? 1 : g;
	e = 0;
	p = 0;
	ready_clear = 1;
	gain_wr = 1;
	gain_wdata = 24'(g);
	offset_wr = 1;
	offset_wdata = 24'(o);
	step(1);
	ready_clear = 0;
	gain_wr = 0;
	offset_wr = 0;
	start = 1;
	step(1);
	for (int k = 1; k <= 2 * gx; k++)
	begin
		d = (k <= gx) ? dn : dx;
		v = (d > 0) && (k % d == 0);
		thermal_osc_in = v;
		if (v && !p) e += (k <= gx) ? 1 : -1;
		p = v;
		if (k == 2) start = 0;
		ck("max_cfg", 24'(k > gx), 24'(thermal_osc_max_cfg));
		ck("status", 24'h6, 24'({thermal_osc_enable, busy, result_ready}));
		step(1);
	end
	thermal_osc_in = 0;
	step(2);
	ck("result", 24'(o + e), result);
	ck("row_result", 24'(r), result);
	ck("offset", 24'(o), offset_value);
	ck("ready", 24'h1, 24'(result_ready));
endtask
initial
begin
	step(8);
	rst_n = 1;
	ck("gain", 24'h0, gain_value);
	foreach (rows[i]) conv(rows[i][0], rows[i][1], rows[i][2], rows[i][3], rows[i][4]);
	ready_clear = 1;
	write_protect = 1;
	gain_wr = 1;
	gain_wdata = 24'h3;
	step(1);
	ready_clear = 0;
	ck("refused", 24'h1, 24'(write_refused));
	ck("gain", 24'h5, gain_value);
	ck("ready", 24'h0, 24'(result_ready));
	debug_access = 1;
	cal_wr = 1;
	frequency_trim_wdata = 6'h2A;
	temperature_trim_wdata = 6'h15;
	step(1);
	gain_wr = 0;
	cal_wr = 0;
	debug_access = 0;
	start = 1;
	ck("gain", 24'h3, gain_value);
	ck("trims", 24'hA95, 24'({frequency_trim, temperature_trim}));
	step(1);
	start = 0;
	ck("busy", 24'h1, 24'(busy));
	step(8);
	ck("ready", 24'h1, 24'(result_ready));
	// reset in the middle of a conversion
	start = 1;
	step(1);
	start = 0;
	step(2);
	rst_n = 0;
	step(1);
	ck("reset", 24'h0, 24'({busy, result_ready, thermal_osc_enable, write_refused}));
	ck("gain", 24'h0, gain_value);
	ck("result", 24'h0, result);
	rst_n = 1;
	step(1);
	start = 1;
	step(1);
	start = 0;
	ck("busy", 24'h1, 24'(busy));
	conclude;
end
initial
begin
	#50000;
	miscompares++;
	conclude;
end
endmodule // tfs_sensor_tb
`default_nettype wire
